// ===== hw/cpr_regs.sv
// Processor register set: program counter, status word, stack pointer, banks, extensions
// Summary of operation
// - Program counter 20 bits, advances by length
// - Branch loads program counter from target; near branch takes the upper 4 bits from CS
// - Reset loads vector from bytes 0000H/0001H
// - Status word 8 bits, resets to 06H
// - Status pushed on ack, restored by returns
// - Enable flag clear refuses maskable requests
// - Enabled: priority, mask, specification decide acceptance
// - Disable and ack clear flag, enable sets
// - Zero flag set on zero result
// - Two bank bits choose one of four
// - Auxiliary carry from bit 3 carry/borrow
// - Lower than in-service priority not acknowledged
// - Carry: arithmetic, rotate shift-out, bit accumulator
// - Stack pointer 16 bits, internal RAM only
// - Decrement before save, increment after restore
// - Stack pointer low bit forced to zero
// - Four banks of eight bytes at FFEE0H
// - Byte access and four 16-bit pairs
// - Extension registers give upper address bits
// - Extension bits 7 to 4 read zero
// - Function registers decode FFF00H-FFFFFH with widths
`timescale 1ns/1ps
module cpr_regs
    import cpr_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_ce,
    output logic o_vec_rd,
    output logic [19:0] o_vec_addr,
    input wire logic i_vec_valid,
    input wire logic [7:0] i_vec_data,
    output logic o_run,
    input wire logic i_pc_advance,
    input wire logic [2:0] i_pc_len,
    input wire logic i_branch,
    input wire logic i_branch_near,
    input wire logic [19:0] i_branch_target,
    output logic [19:0] o_pc,
    input wire cpr_alu_s i_alu,
    input wire logic i_ei,
    input wire logic i_di,
    input wire logic i_sel_bank,
    input wire logic [1:0] i_bank,
    input wire logic i_push_status_instruction,
    input wire logic i_restore_psw,
    input wire logic [7:0] i_restore_data,
    input wire logic i_psw_we,
    input wire logic [7:0] i_psw_wdata,
    output logic [7:0] o_psw,
    input wire logic i_irq_pending,
    input wire logic i_irq_mask,
    input wire logic [1:0] i_irq_prio,
    input wire logic i_int_ack,
    output logic o_irq_accept,
    input wire logic i_sp_we,
    input wire logic [15:0] i_sp_wdata,
    input wire logic i_stk_push,
    input wire logic i_stk_pop,
    output logic [19:0] o_stk_addr,
    output logic [7:0] o_stk_psw,
    output logic [15:0] o_sp,
    input wire logic i_es_we,
    input wire logic i_cs_we,
    input wire logic [7:0] i_ext_wdata,
    input wire logic [15:0] i_data_offset,
    output logic [19:0] o_data_addr,
    output logic [7:0] o_es,
    output logic [7:0] o_cs,
    input wire logic [2:0] i_gpr_sel,
    input wire logic i_gpr_we,
    input wire logic [7:0] i_gpr_wdata,
    input wire logic [1:0] i_pair_sel,
    input wire logic i_pair_we,
    input wire logic [15:0] i_pair_wdata,
    output logic [7:0] o_gpr_rdata,
    output logic [15:0] o_pair_rdata,
    input wire cpr_mem_s i_mem,
    output logic o_mem_ack,
    output logic o_mem_hit,
    output logic [15:0] o_mem_rdata
);
    cpr_state_e state_reg;
    logic [19:0] pc_reg;
    logic [7:0] psw_reg;
    logic [15:0] sp_reg;
    logic [3:0] es_reg;
    logic [3:0] cs_reg;
    logic [7:0] vec_lo_reg;
    logic [7:0] gpr_mem [0:31];
    logic [1:0] bank;
    logic acc;
    logic in_gpr;
    logic in_sfr;
    logic [4:0] gidx;
    logic sel_sp;
    logic sel_psw;
    logic sel_es;
    logic sel_cs;
    logic mapped;
    logic bus_wr;
    logic [7:0] psw_next;
    logic [7:0] bus_byte;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [15:0] sp_next;

    function automatic logic in_range(input logic [19:0] a, input logic [19:0] lo, input logic [19:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [7:0] set_bit(input logic [7:0] v, input logic [2:0] p, input logic b);
        logic [7:0] r;
        r = v;
        r[p] = b;
        set_bit = r;
    endfunction

    function automatic logic [7:0] bus_merge(input logic [7:0] old, input cpr_mem_s m);
        bus_merge = (m.size == CPR_SZ_BIT) ? set_bit(old, m.bitpos, m.wdata[0]) : m.wdata[7:0];
    endfunction

    assign acc = i_ce && state_reg == CPR_ST_RUN;
    assign bank = {psw_reg[PSW_BANK_SELECT_HIGH], psw_reg[PSW_BANK_SELECT_LOW]};
    assign in_gpr = in_range(i_mem.addr, GPR_BASE, GPR_LAST);
    assign in_sfr = in_range(i_mem.addr, SFR_BASE, SFR_LAST);
    assign gidx = i_mem.addr[4:0];
    // Each function register takes only its allowed widths; words need an even address
    assign sel_sp = in_sfr && ((i_mem.addr == ADDR_SP && i_mem.size != CPR_SZ_BIT)
                    || (i_mem.addr == ADDR_SP + 20'h00001 && i_mem.size == CPR_SZ_BYTE));
    assign sel_psw = in_sfr && i_mem.addr == ADDR_PSW && i_mem.size != CPR_SZ_WORD;
    assign sel_es = in_sfr && i_mem.addr == ADDR_ES && i_mem.size == CPR_SZ_BYTE;
    assign sel_cs = in_sfr && i_mem.addr == ADDR_CS && i_mem.size == CPR_SZ_BYTE;
    assign mapped = (in_gpr && (i_mem.size != CPR_SZ_WORD || !i_mem.addr[0]))
                    || sel_sp || sel_psw || sel_es || sel_cs;
    assign bus_wr = acc && i_mem.req && i_mem.we && mapped;
    assign bus_byte = bus_merge(psw_reg, i_mem);

    // Reset vector fetch sequence
    assign o_vec_rd = i_ce && state_reg != CPR_ST_RUN;
    assign o_vec_addr = (state_reg == CPR_ST_VHI) ? VEC_HI_ADDR : VEC_LO_ADDR;
    assign o_run = state_reg == CPR_ST_RUN;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_reg <= CPR_ST_VLO;
            vec_lo_reg <= 8'h00;
        end else if (i_ce) begin
            case (state_reg)
                CPR_ST_VLO: begin
                    if (i_vec_valid) begin
                        vec_lo_reg <= i_vec_data;
                        state_reg <= CPR_ST_VHI;
                    end
                end
                CPR_ST_VHI: begin
                    if (i_vec_valid) begin
                        state_reg <= CPR_ST_RUN;
                    end
                end
                CPR_ST_RUN: begin
                    state_reg <= CPR_ST_RUN;
                end
                default: begin
                    state_reg <= CPR_ST_VLO;
                end
            endcase
        end
    end

    // Program counter
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pc_reg <= 20'h00000;
        end else if (i_ce) begin
            if (state_reg == CPR_ST_VHI && i_vec_valid) begin
                pc_reg <= {4'h0, i_vec_data, vec_lo_reg};
            end else if (acc && i_branch) begin
                pc_reg <= i_branch_near ? {cs_reg, i_branch_target[15:0]} : i_branch_target;
            end else if (acc && i_pc_advance) begin
                pc_reg <= pc_reg + {17'h00000, i_pc_len};
            end
        end
    end
    assign o_pc = pc_reg;

    // Status word update
    assign sum5 = i_alu.sub ? {1'b0, i_alu.opa[3:0]} - {1'b0, i_alu.opb[3:0]} - {4'h0, i_alu.cin}
                            : {1'b0, i_alu.opa[3:0]} + {1'b0, i_alu.opb[3:0]} + {4'h0, i_alu.cin};
    assign sum9 = i_alu.sub ? {1'b0, i_alu.opa} - {1'b0, i_alu.opb} - {8'h00, i_alu.cin}
                            : {1'b0, i_alu.opa} + {1'b0, i_alu.opb} + {8'h00, i_alu.cin};

    always_comb begin
        psw_next = psw_reg;
        if (i_alu.upd_z) begin
            psw_next[PSW_Z] = (i_alu.result == 16'h0000);
        end
        if (i_alu.upd_ac) begin
            psw_next[PSW_AC] = sum5[4];
        end
        case (i_alu.cy_src)
            CPR_CY_ARITH: psw_next[PSW_CY] = sum9[8];
            CPR_CY_SHIFT: psw_next[PSW_CY] = i_alu.cy_value;
            CPR_CY_BIT: psw_next[PSW_CY] = i_alu.cy_value;
            default: psw_next[PSW_CY] = psw_reg[PSW_CY];
        endcase
        if (i_sel_bank) begin
            psw_next[PSW_BANK_SELECT_HIGH] = i_bank[1];
            psw_next[PSW_BANK_SELECT_LOW] = i_bank[0];
        end
        if (i_ei) begin
            psw_next[PSW_IE] = 1'b1;
        end
        if (i_di || i_int_ack) begin
            psw_next[PSW_IE] = 1'b0;
        end
        if (i_psw_we) begin
            psw_next = i_psw_wdata;
        end
        if (bus_wr && sel_psw) begin
            psw_next = bus_byte;
        end
        if (i_restore_psw) begin
            psw_next = i_restore_data;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            psw_reg <= PSW_RESET;
        end else if (acc) begin
            psw_reg <= psw_next;
        end
    end
    assign o_psw = psw_reg;

    // Interrupt acceptance
    assign o_irq_accept = psw_reg[PSW_IE] && i_irq_pending && !i_irq_mask
                          && (i_irq_prio <= {psw_reg[PSW_INSERVICE_PRIORITY_HIGH], psw_reg[PSW_INSERVICE_PRIORITY_LOW]});

    // Stack pointer
    always_comb begin
        sp_next = sp_reg;
        if (i_stk_push || i_push_status_instruction || i_int_ack) begin
            sp_next = sp_reg - STK_STEP;
        end else if (i_stk_pop) begin
            sp_next = sp_reg + STK_STEP;
        end
        if (i_sp_we) begin
            sp_next = i_sp_wdata;
        end
        if (bus_wr && sel_sp) begin
            if (i_mem.size == CPR_SZ_WORD) begin
                sp_next = i_mem.wdata;
            end else if (i_mem.addr[0]) begin
                sp_next = {i_mem.wdata[7:0], sp_reg[7:0]};
            end else begin
                sp_next = {sp_reg[15:8], i_mem.wdata[7:0]};
            end
        end
        sp_next[0] = 1'b0;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sp_reg <= 16'h0000;
        end else if (acc) begin
            sp_reg <= sp_next;
        end
    end
    assign o_sp = sp_reg;
    // Save address is below the pointer, restore address is the pointer itself
    assign o_stk_addr = {RAM_PAGE, (i_stk_push || i_push_status_instruction || i_int_ack) ? sp_reg - STK_STEP : sp_reg};
    assign o_stk_psw = psw_reg;

    // Extension registers
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            es_reg <= ES_RESET;
            cs_reg <= CS_RESET;
        end else if (acc) begin
            if (bus_wr && sel_es) begin
                es_reg <= i_mem.wdata[3:0];
            end else if (i_es_we) begin
                es_reg <= i_ext_wdata[3:0];
            end
            if (bus_wr && sel_cs) begin
                cs_reg <= i_mem.wdata[3:0];
            end else if (i_cs_we) begin
                cs_reg <= i_ext_wdata[3:0];
            end
        end
    end
    assign o_es = {4'h0, es_reg};
    assign o_cs = {4'h0, cs_reg};
    assign o_data_addr = {es_reg, i_data_offset};

    // General-purpose register banks
    always_ff @(posedge i_clock) begin
        if (acc) begin
            if (i_gpr_we) begin
                gpr_mem[{bank, i_gpr_sel}] <= i_gpr_wdata;
            end
            if (i_pair_we) begin
                gpr_mem[{bank, i_pair_sel, 1'b0}] <= i_pair_wdata[7:0];
                gpr_mem[{bank, i_pair_sel, 1'b1}] <= i_pair_wdata[15:8];
            end
            if (bus_wr && in_gpr) begin
                gpr_mem[gidx] <= bus_merge(gpr_mem[gidx], i_mem);
                if (i_mem.size == CPR_SZ_WORD) begin
                    gpr_mem[{gidx[4:1], 1'b1}] <= i_mem.wdata[15:8];
                end
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_gpr_rdata <= 8'h00;
            o_pair_rdata <= 16'h0000;
        end else if (i_ce) begin
            o_gpr_rdata <= gpr_mem[{bank, i_gpr_sel}];
            o_pair_rdata <= {gpr_mem[{bank, i_pair_sel, 1'b1}], gpr_mem[{bank, i_pair_sel, 1'b0}]};
        end
    end

    // Data bus read path, one cycle after the request
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_mem_ack <= 1'b0;
            o_mem_hit <= 1'b0;
            o_mem_rdata <= 16'h0000;
        end else if (i_ce) begin
            o_mem_ack <= acc && i_mem.req;
            o_mem_hit <= acc && i_mem.req && mapped;
            o_mem_rdata <= 16'h0000;
            if (acc && i_mem.req && !i_mem.we && mapped) begin
                if (in_gpr && i_mem.size == CPR_SZ_WORD) begin
                    o_mem_rdata <= {gpr_mem[{gidx[4:1], 1'b1}], gpr_mem[gidx]};
                end else if (in_gpr) begin
                    o_mem_rdata <= {8'h00, gpr_mem[gidx]};
                end else if (sel_sp && i_mem.size == CPR_SZ_WORD) begin
                    o_mem_rdata <= sp_reg;
                end else if (sel_sp) begin
                    o_mem_rdata <= {8'h00, i_mem.addr[0] ? sp_reg[15:8] : sp_reg[7:0]};
                end else if (sel_psw) begin
                    o_mem_rdata <= {8'h00, psw_reg};
                end else if (sel_es) begin
                    o_mem_rdata <= {8'h00, o_es};
                end else begin
                    o_mem_rdata <= {8'h00, o_cs};
                end
            end
        end
    end

    chk_sp_even_word: assert property (@(posedge i_clock) disable iff (i_rst) !sp_reg[0])
        else $error("stack pointer holds an odd value");
    chk_pc_step_len: assert property (@(posedge i_clock) disable iff (i_rst)
        acc && i_pc_advance && !i_branch |=> pc_reg == $past(pc_reg) + {17'h00000, $past(i_pc_len)})
        else $error("program counter did not advance by instruction length");
    chk_branch_far_load: assert property (@(posedge i_clock) disable iff (i_rst)
        acc && i_branch && !i_branch_near |=> pc_reg == $past(i_branch_target))
        else $error("branch target not loaded");
    chk_vector_load_pc: assert property (@(posedge i_clock) disable iff (i_rst)
        i_ce && state_reg == CPR_ST_VHI && i_vec_valid |=> o_run && pc_reg == {4'h0, $past(i_vec_data), vec_lo_reg})
        else $error("reset vector not loaded into program counter");
    chk_psw_after_reset: assert property (@(posedge i_clock) disable iff (i_rst)
        $fell(i_rst) |-> psw_reg == PSW_RESET)
        else $error("status word wrong after reset");
    chk_ie_blocks_irq: assert property (@(posedge i_clock) disable iff (i_rst)
        !psw_reg[PSW_IE] |-> !o_irq_accept)
        else $error("request accepted while interrupts disabled");
    chk_ack_clears_ie: assert property (@(posedge i_clock) disable iff (i_rst)
        acc && i_int_ack && !i_restore_psw && !i_psw_we && !(bus_wr && sel_psw) |=> !psw_reg[PSW_IE])
        else $error("acknowledge left interrupts enabled");
    chk_push_decrement: assert property (@(posedge i_clock) disable iff (i_rst)
        acc && i_stk_push && !i_sp_we && !bus_wr |=> sp_reg == $past(sp_reg) - STK_STEP)
        else $error("stack pointer not decremented on save");
    chk_ext_high_zero: assert property (@(posedge i_clock) disable iff (i_rst)
        o_es[7:4] == 4'h0 && o_cs[7:4] == 4'h0)
        else $error("extension upper bits not zero");
    chk_unmapped_read_zero: assert property (@(posedge i_clock) disable iff (i_rst)
        o_mem_ack && !o_mem_hit |-> o_mem_rdata == 16'h0000)
        else $error("unassigned address returned data");
endmodule

// ===== hw/cpr_pkg.sv
// Constants, types and address map of the processor register set
package cpr_pkg;
    localparam logic [7:0] PSW_RESET = 8'h06;
    localparam logic [3:0] ES_RESET = 4'hF;
    localparam logic [3:0] CS_RESET = 4'h0;
    localparam int PSW_CY = 0;
    localparam int PSW_INSERVICE_PRIORITY_LOW = 1;
    localparam int PSW_INSERVICE_PRIORITY_HIGH = 2;
    localparam int PSW_BANK_SELECT_LOW = 3;
    localparam int PSW_AC = 4;
    localparam int PSW_BANK_SELECT_HIGH = 5;
    localparam int PSW_Z = 6;
    localparam int PSW_IE = 7;
    localparam logic [19:0] VEC_LO_ADDR = 20'h00000;
    localparam logic [19:0] VEC_HI_ADDR = 20'h00001;
    localparam logic [19:0] GPR_BASE = 20'hFFEE0;
    localparam logic [19:0] GPR_LAST = 20'hFFEFF;
    localparam logic [19:0] SFR_BASE = 20'hFFF00;
    localparam logic [19:0] SFR_LAST = 20'hFFFFF;
    localparam logic [19:0] ADDR_SP = 20'hFFFF8;
    localparam logic [19:0] ADDR_PSW = 20'hFFFFA;
    localparam logic [19:0] ADDR_CS = 20'hFFFFC;
    localparam logic [19:0] ADDR_ES = 20'hFFFFD;
    localparam logic [3:0] RAM_PAGE = 4'hF;
    localparam logic [15:0] STK_STEP = 16'h0002;

    typedef enum logic [1:0] {
        CPR_SZ_BIT = 2'h0,
        CPR_SZ_BYTE = 2'h1,
        CPR_SZ_WORD = 2'h2
    } cpr_size_e;

    typedef enum logic [2:0] {
        CPR_ST_VLO = 3'b001,
        CPR_ST_VHI = 3'b010,
        CPR_ST_RUN = 3'b100
    } cpr_state_e;

    typedef enum logic [1:0] {
        CPR_CY_KEEP = 2'h0,
        CPR_CY_ARITH = 2'h1,
        CPR_CY_SHIFT = 2'h2,
        CPR_CY_BIT = 2'h3
    } cpr_cysrc_e;

    typedef struct packed {
        logic req;
        logic we;
        logic [19:0] addr;
        cpr_size_e size;
        logic [2:0] bitpos;
        logic [15:0] wdata;
    } cpr_mem_s;

    typedef struct packed {
        logic upd_z;
        logic upd_ac;
        cpr_cysrc_e cy_src;
        logic sub;
        logic cin;
        logic [7:0] opa;
        logic [7:0] opb;
        logic [15:0] result;
        logic cy_value;
    } cpr_alu_s;
endpackage

// ===== tb/cpr_cpu_model.sv
// Decode side model that answers the reset vector fetch, slowly or promptly
`timescale 1ns/1ps
module cpr_cpu_model
    import cpr_pkg::*;
#(
    parameter logic [15:0] RESET_VECTOR = 16'h2468,
    parameter int WAIT_CYCLES = 2
)(
    input wire logic i_clock,
    input wire logic i_vec_rd,
    input wire logic [19:0] i_vec_addr,
    output logic o_vec_valid,
    output logic [7:0] o_vec_data
);
    int wait_cnt = 0;
    logic [7:0] last_reg = 8'h00;
    initial begin
        o_vec_valid = 1'b0;
        o_vec_data = 8'h00;
    end
    // Low byte at the even address, high byte at the odd one
    always @(posedge i_clock) begin
        #1;
        if (i_vec_rd === 1'b1 && !o_vec_valid && wait_cnt >= WAIT_CYCLES) begin
            o_vec_valid = 1'b1;
            o_vec_data = (i_vec_addr === VEC_HI_ADDR) ? RESET_VECTOR[15:8] : RESET_VECTOR[7:0];
            last_reg = o_vec_data;
            wait_cnt = 0;
        end else begin
            o_vec_valid = 1'b0;
            o_vec_data = ~last_reg;
            wait_cnt = (i_vec_rd === 1'b1) ? wait_cnt + 1 : 0;
        end
    end
endmodule

// ===== tb/test_cpu_processor_registers.sv
// Self-checking testbench of the processor register set
`timescale 1ns/1ps
module test_cpu_processor_registers;
    import cpr_pkg::*;
    localparam logic [15:0] RST_VEC = 16'h2468;
    logic i_clock, i_rst, i_ce, i_pc_advance, i_branch, i_branch_near, i_ei, i_di, i_sel_bank, i_push_status_instruction;
    logic i_restore_psw, i_psw_we, i_irq_pending, i_irq_mask, i_int_ack, i_sp_we, i_stk_push, i_stk_pop;
    logic i_es_we, i_cs_we, i_gpr_we, i_pair_we, i_vec_valid;
    logic [7:0] i_vec_data, i_restore_data, i_psw_wdata, i_ext_wdata, i_gpr_wdata;
    logic [2:0] i_pc_len, i_gpr_sel;
    logic [1:0] i_bank, i_irq_prio, i_pair_sel;
    logic [19:0] i_branch_target;
    logic [15:0] i_sp_wdata, i_data_offset, i_pair_wdata;
    cpr_alu_s i_alu;
    cpr_mem_s i_mem;
    logic o_vec_rd, o_run, o_irq_accept, o_mem_ack, o_mem_hit;
    logic [19:0] o_vec_addr, o_pc, o_stk_addr, o_data_addr;
    logic [7:0] o_psw, o_stk_psw, o_es, o_cs, o_gpr_rdata;
    logic [15:0] o_sp, o_pair_rdata, o_mem_rdata;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;

    cpr_regs dut_u (.i_clock, .i_rst, .i_ce, .o_vec_rd, .o_vec_addr, .i_vec_valid, .i_vec_data, .o_run,
        .i_pc_advance, .i_pc_len, .i_branch, .i_branch_near, .i_branch_target, .o_pc, .i_alu, .i_ei, .i_di,
        .i_sel_bank, .i_bank, .i_push_status_instruction, .i_restore_psw, .i_restore_data, .i_psw_we, .i_psw_wdata, .o_psw,
        .i_irq_pending, .i_irq_mask, .i_irq_prio, .i_int_ack, .o_irq_accept, .i_sp_we, .i_sp_wdata,
        .i_stk_push, .i_stk_pop, .o_stk_addr, .o_stk_psw, .o_sp, .i_es_we, .i_cs_we, .i_ext_wdata,
        .i_data_offset, .o_data_addr, .o_es, .o_cs, .i_gpr_sel, .i_gpr_we, .i_gpr_wdata, .i_pair_sel,
        .i_pair_we, .i_pair_wdata, .o_gpr_rdata, .o_pair_rdata, .i_mem, .o_mem_ack, .o_mem_hit, .o_mem_rdata);

    cpr_cpu_model #(.RESET_VECTOR(RST_VEC), .WAIT_CYCLES(2)) model_u (.i_clock(i_clock), .i_vec_rd(o_vec_rd),
        .i_vec_addr(o_vec_addr), .o_vec_valid(i_vec_valid), .o_vec_data(i_vec_data));

    always #5 i_clock = ~i_clock;

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_mismatch++;
            $display("[ERR] t=%0t run did not finish", $time);
            give_verdict();
        end
    end

    task automatic step();
        @(posedge i_clock);
        #1;
    endtask

    task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic mem(input logic we, input logic [19:0] addr, input cpr_size_e sz, input logic [15:0] wd,
                       input logic hit, input logic [15:0] rd, input string what);
        i_mem = '{req: 1'b1, we: we, addr: addr, size: sz, bitpos: 3'h0, wdata: wd};
        step();
        i_mem.req = 1'b0;
        chk(o_mem_ack, 20'h1, what);
        chk(o_mem_hit, hit, what);
        chk(o_mem_rdata, rd, what);
        step();
    endtask

    task automatic t_reset();
        chk(o_psw, 20'h06, "psw reset");
        chk(o_es, 20'h0F, "es reset");
        chk(o_cs, 20'h00, "cs reset");
        chk(o_vec_addr, VEC_LO_ADDR, "vector address");
        chk(o_vec_rd, 20'h1, "vector read");
        for (int i = 0; i < 40 && o_run !== 1'b1; i++) step();
        chk(o_run, 20'h1, "run");
        chk(o_pc, {4'h0, RST_VEC}, "pc from vector");
        chk(o_vec_rd, 20'h0, "vector fetch done");
    endtask

    task automatic t_pc();
        i_pc_advance = 1'b1;
        i_pc_len = 3'h3;
        step();
        chk(o_pc, 20'h0246B, "advance 3");
        i_pc_len = 3'h7;
        step();
        chk(o_pc, 20'h02472, "advance 7");
        i_ce = 1'b0;
        step();
        chk(o_pc, 20'h02472, "frozen");
        i_ce = 1'b1;
        i_branch = 1'b1;
        i_branch_target = 20'hFFFFE;
        step();
        chk(o_pc, 20'hFFFFE, "branch over advance");
        i_branch = 1'b0;
        i_pc_len = 3'h3;
        step();
        chk(o_pc, 20'h00001, "20-bit wrap");
        i_pc_advance = 1'b0;
        i_cs_we = 1'b1;
        i_ext_wdata = 8'hF5;
        step();
        i_cs_we = 1'b0;
        chk(o_cs, 20'h05, "cs upper nibble");
        i_branch = 1'b1;
        i_branch_near = 1'b1;
        i_branch_target = 20'h01234;
        step();
        i_branch = 1'b0;
        chk(o_pc, 20'h51234, "near branch");
    endtask

    task automatic t_sp();
        i_sp_we = 1'b1;
        i_sp_wdata = 16'hFE21;
        step();
        i_sp_we = 1'b0;
        chk(o_sp, 20'hFE20, "odd sp");
        i_stk_push = 1'b1;
        i_push_status_instruction = 1'b1;
        #1;
        chk(o_stk_addr, 20'hFFE1E, "save address");
        chk(o_stk_psw, 20'h06, "pushed status");
        step();
        i_stk_push = 1'b0;
        i_push_status_instruction = 1'b0;
        chk(o_sp, 20'hFE1E, "push");
        i_stk_pop = 1'b1;
        step();
        i_stk_pop = 1'b0;
        chk(o_sp, 20'hFE20, "pop");
        mem(1'b0, ADDR_SP, CPR_SZ_WORD, 16'h0, 1'b1, 16'hFE20, "sp word read");
    endtask

    task automatic t_irq();
        i_irq_pending = 1'b1;
        #1;
        chk(o_irq_accept, 20'h0, "disabled");
        i_ei = 1'b1;
        step();
        i_ei = 1'b0;
        chk(o_irq_accept, 20'h1, "enabled");
        i_irq_mask = 1'b1;
        #1;
        chk(o_irq_accept, 20'h0, "masked");
        i_irq_mask = 1'b0;
        i_psw_we = 1'b1;
        i_psw_wdata = 8'h82;
        i_irq_prio = 2'h2;
        step();
        i_psw_we = 1'b0;
        chk(o_irq_accept, 20'h0, "lower priority");
        i_irq_prio = 2'h1;
        #1;
        chk(o_irq_accept, 20'h1, "equal priority");
        i_int_ack = 1'b1;
        i_ei = 1'b1;
        step();
        i_int_ack = 1'b0;
        i_ei = 1'b0;
        chk(o_psw[PSW_IE], 20'h0, "ack clears");
        chk(o_irq_accept, 20'h0, "refused after ack");
        chk(o_sp, 20'hFE1E, "ack saves");
        i_ei = 1'b1;
        step();
        i_ei = 1'b0;
        i_di = 1'b1;
        step();
        i_di = 1'b0;
        chk(o_psw[PSW_IE], 20'h0, "disable");
    endtask

    task automatic t_alu();
        i_alu = '0;
        i_alu.upd_z = 1'b1;
        i_alu.upd_ac = 1'b1;
        i_alu.cy_src = CPR_CY_ARITH;
        i_alu.opa = 8'h0F;
        i_alu.opb = 8'h01;
        i_alu.result = 16'h0010;
        step();
        chk({o_psw[PSW_Z], o_psw[PSW_AC], o_psw[PSW_CY]}, 20'h2, "add 0F+01");
        i_alu.opa = 8'hFF;
        i_alu.result = 16'h0000;
        step();
        chk({o_psw[PSW_Z], o_psw[PSW_AC], o_psw[PSW_CY]}, 20'h7, "add FF+01");
        i_alu.sub = 1'b1;
        i_alu.opa = 8'h10;
        i_alu.result = 16'h000F;
        step();
        chk({o_psw[PSW_Z], o_psw[PSW_AC], o_psw[PSW_CY]}, 20'h2, "sub 10-01");
        i_alu = '0;
        i_alu.cy_src = CPR_CY_SHIFT;
        i_alu.cy_value = 1'b1;
        step();
        chk(o_psw[PSW_CY], 20'h1, "shift out");
        i_alu.cy_src = CPR_CY_BIT;
        i_alu.cy_value = 1'b0;
        step();
        i_alu = '0;
        chk(o_psw[PSW_CY], 20'h0, "bit accumulator");
    endtask

    task automatic t_bank();
        i_sel_bank = 1'b1;
        i_bank = 2'h2;
        step();
        i_sel_bank = 1'b0;
        chk({o_psw[PSW_BANK_SELECT_HIGH], o_psw[PSW_BANK_SELECT_LOW]}, 20'h2, "bank 2");
        i_gpr_we = 1'b1;
        i_gpr_sel = 3'h3;
        i_gpr_wdata = 8'hA5;
        step();
        i_gpr_we = 1'b0;
        mem(1'b0, 20'hFFEF3, CPR_SZ_BYTE, 16'h0, 1'b1, 16'h00A5, "byte reg");
        i_pair_we = 1'b1;
        i_pair_sel = 2'h1;
        i_pair_wdata = 16'h1234;
        step();
        i_pair_we = 1'b0;
        step();
        chk(o_pair_rdata, 20'h1234, "pair read");
        mem(1'b0, 20'hFFEF2, CPR_SZ_WORD, 16'h0, 1'b1, 16'h1234, "pair word");
        i_sel_bank = 1'b1;
        i_bank = 2'h3;
        i_gpr_we = 1'b1;
        i_gpr_sel = 3'h7;
        i_gpr_wdata = 8'h5A;
        step();
        i_sel_bank = 1'b0;
        step();
        i_gpr_we = 1'b0;
        step();
        chk(o_gpr_rdata, 20'h5A, "last reg");
        mem(1'b0, GPR_LAST, CPR_SZ_BYTE, 16'h0, 1'b1, 16'h005A, "last address");
        mem(1'b1, GPR_LAST, CPR_SZ_BIT, 16'h0001, 1'b1, 16'h0000, "bit write");
        mem(1'b0, GPR_LAST, CPR_SZ_BYTE, 16'h0, 1'b1, 16'h005B, "bit write lands");
    endtask

    task automatic t_mem();
        mem(1'b1, ADDR_PSW, CPR_SZ_BYTE, 16'h0041, 1'b1, 16'h0000, "psw write");
        mem(1'b0, ADDR_PSW, CPR_SZ_BIT, 16'h0, 1'b1, 16'h0041, "psw bit read");
        mem(1'b0, ADDR_PSW, CPR_SZ_WORD, 16'h0, 1'b0, 16'h0000, "psw word refused");
        mem(1'b1, SFR_BASE, CPR_SZ_BYTE, 16'h00FF, 1'b0, 16'h0000, "unmapped write");
        mem(1'b0, SFR_BASE, CPR_SZ_BYTE, 16'h0, 1'b0, 16'h0000, "unmapped read");
        mem(1'b1, ADDR_ES, CPR_SZ_BYTE, 16'h00F3, 1'b1, 16'h0000, "es write");
        chk(o_es, 20'h03, "es upper nibble");
        i_data_offset = 16'hBEEF;
        #1;
        chk(o_data_addr, 20'h3BEEF, "data address");
        i_restore_psw = 1'b1;
        i_restore_data = 8'h41;
        i_psw_we = 1'b1;
        step();
        i_restore_psw = 1'b0;
        i_psw_we = 1'b0;
        chk(o_psw, 20'h41, "restore");
    endtask

    initial begin
        i_clock = 1'b0;
        {i_ce, i_pc_advance, i_branch, i_branch_near, i_ei, i_di, i_sel_bank, i_push_status_instruction, i_restore_psw} = '0;
        {i_psw_we, i_irq_pending, i_irq_mask, i_int_ack, i_sp_we, i_stk_push, i_stk_pop} = '0;
        {i_es_we, i_cs_we, i_gpr_we, i_pair_we, i_restore_data, i_psw_wdata, i_ext_wdata, i_gpr_wdata} = '0;
        {i_pc_len, i_gpr_sel, i_bank, i_irq_prio, i_pair_sel, i_branch_target} = '0;
        {i_sp_wdata, i_data_offset, i_pair_wdata} = '0;
        i_alu = '0;
        i_mem = '0;
        i_rst = 1'b1;
        i_ce = 1'b1;
        repeat (3) @(posedge i_clock);
        #1;
        i_rst = 1'b0;
        t_reset();
        t_pc();
        t_sp();
        t_irq();
        t_alu();
        t_bank();
        t_mem();
        give_verdict();
    end
endmodule
